//--- rtl/l2c_pkg.sv
/*
 * package for the second-level cache control register block: bit positions,
 * field codes, reset value and invalidation timing.
 * assumes a single core clock domain at 125 MHz.
 */
package l2c_pkg;

  localparam int unsigned CLK_PERIOD_PS   = 8000;
  // invalidation walk, about 32K core clocks, one tag entry per cycle
  localparam int unsigned TAG_INDEX_W     = 15;
  localparam int unsigned INVAL_CYCLES    = 32768;
  localparam logic [14:0] TAG_LAST        = 15'h7fff;
  localparam int unsigned DLL_LOCK_CLKS   = 640;
  localparam int unsigned DLL_CNT_W       = 10;

  // hold times in ps
  localparam int unsigned HOLD_0P5_PS     = 500;
  localparam int unsigned HOLD_1P0_PS     = 1000;

  localparam int unsigned BIT_ENABLE      = 0;
  localparam int unsigned BIT_PARITY      = 1;
  localparam int unsigned POS_SIZE        = 2;
  localparam int unsigned POS_CLK         = 4;
  localparam int unsigned POS_RAM         = 7;
  localparam int unsigned BIT_DATA_ONLY   = 9;
  localparam int unsigned BIT_INVAL       = 10;
  localparam int unsigned BIT_SLEEP       = 11;
  localparam int unsigned BIT_WT          = 12;
  localparam int unsigned BIT_TS          = 13;
  localparam int unsigned POS_HOLD        = 14;
  localparam int unsigned BIT_DLL_SLOW    = 16;
  localparam int unsigned BIT_DIFF        = 17;
  localparam int unsigned BIT_BYPASS      = 18;
  localparam int unsigned BIT_BUSY        = 31;
  localparam logic [31:0] WRITE_MASK      = 32'h0007_ffff;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  localparam logic [1:0]  SIZE_256K       = 2'h1;
  localparam logic [1:0]  SIZE_512K       = 2'h2;
  localparam logic [1:0]  SIZE_1M         = 2'h3;

  localparam logic [2:0]  CLK_OFF         = 3'h0;
  localparam logic [2:0]  CLK_DIV1        = 3'h1;
  localparam logic [2:0]  CLK_DIV1P5      = 3'h2;
  localparam logic [2:0]  CLK_DIV2        = 3'h4;
  localparam logic [2:0]  CLK_DIV2P5      = 3'h5;
  localparam logic [2:0]  CLK_DIV3        = 3'h6;

  localparam logic [1:0]  RAM_FLOW        = 2'h0;
  localparam logic [1:0]  RAM_PIPE        = 2'h2;
  localparam logic [1:0]  RAM_LATE        = 2'h3;

  typedef enum logic [1:0] {CDIV_NONE, CDIV_HALF, CDIV_INT} l2c_cdiv_t;

  // decoded configuration presented to the cache datapath
  typedef struct packed {
    logic       cache_on;
    logic       parity_on;
    logic [1:0] size_sel;
    logic       size_bad;
    logic [1:0] ram_type;
    logic       ram_bad;
    logic       icache_allow;
    logic       write_through;
    logic       l1_push_to_l2;
    logic       drop_miss_store;
    logic       hold_long;
    logic       hold_bad;
  } l2c_cfg_t;

  // clocking controls for the ram clock generator
  typedef struct packed {
    logic       clk_run;
    logic       dll_on;
    logic       dll_slow;
    logic       dll_bypass;
    logic       diff_pair;
    logic [2:0] half_periods;
    logic       ratio_bad;
  } l2c_clkcfg_t;

  // returns core half-cycles per ram clock period for a ratio code
  function automatic logic [2:0] ratio_half_periods(input logic [2:0] code);
    unique case (code)
      CLK_DIV1:   ratio_half_periods = 3'h2;
      CLK_DIV1P5: ratio_half_periods = 3'h3;
      CLK_DIV2:   ratio_half_periods = 3'h4;
      CLK_DIV2P5: ratio_half_periods = 3'h5;
      CLK_DIV3:   ratio_half_periods = 3'h6;
      default:    ratio_half_periods = 3'h0;
    endcase
  endfunction

endpackage

//--- rtl/l2c_inval_walk.sv
/*
 * tag invalidation walker: steps one tag entry per enabled cycle,
 * emitting a clear strobe with the entry index.
 * assumes the tag array accepts one clear per cycle.
 */
`timescale 1ns/1ps
module l2c_inval_walk
  import l2c_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_ce,
  input  wire logic                   i_start,
  output logic                        o_busy,
  output logic                        o_tag_clr,
  output logic [TAG_INDEX_W-1:0]      o_tag_idx
);

  typedef enum logic {WS_IDLE, WS_RUN} l2c_wstate_t;

  typedef struct packed {
    l2c_wstate_t              st;
    logic [TAG_INDEX_W-1:0]   idx;
    logic                     clr;
  } l2c_walk_t;

  l2c_walk_t r;
  l2c_walk_t next_r;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.clr = 1'b0;
    unique case (r.st)
      WS_IDLE: begin
        if (i_start) begin
          next_r.st  = WS_RUN;
          next_r.idx = '0;
        end
      end
      WS_RUN: begin
        next_r.clr = 1'b1;               // clear tag, status and lru [R19]
        if (r.clr && r.idx == TAG_LAST) begin
          next_r.st  = WS_IDLE;          // [R21]
          next_r.clr = 1'b0;
        end else if (r.clr) begin
          next_r.idx = r.idx + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '{st: WS_IDLE, idx: '0, clr: 1'b0};
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_busy    = (r.st == WS_RUN);
  assign o_tag_clr = r.clr;
  assign o_tag_idx = r.idx;

  a_walk_visits_last: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R19]
    (i_ce && r.st == WS_RUN && !(r.clr && r.idx == TAG_LAST)) |=> r.st == WS_RUN)
    else $error("walk ended before last tag entry");

endmodule

//--- rtl/l2c_ctrl.sv
/*
 * second-level cache control register and its global invalidation engine.
 * assumes the special-register port delivers a one-cycle write strobe;
 * reads are combinational-free: the read word is registered every enabled cycle.
 */
// Overview of operation
// [R01] bit 0 enables cache, bit 1 parity
// [R02] bits 2-3 select ram size
// [R03] bits 4-6 set core clock divide ratio
// [R04] bits 7-8 select sram interface type
// [R05] bit 9 set allows instruction caching
// [R06] bit 10 set starts global invalidation
// [R07] bit 11 drives ram sleep automatically
// [R08] bit 12 selects write-through mode
// [R09] bit 13 sends l1 pushes into cache
// [R10] test support drops missing single-beat stores
// [R11] bits 14-15 select output hold time
// [R12] bit 16 puts dll in slow mode
// [R13] bit 17 joins clock outputs differentially
// [R14] bit 18 bypasses the dll
// [R15] bit 31 reads invalidation in progress
// [R16] reset leaves cache and dll disabled
// [R17] software waits 640 ram clocks lock
// [R18] nonzero ratio enables dll automatically
// [R19] hardware walks every tag clearing it
// [R20] invalidate only while cache disabled
// [R21] invalidation about 32k cycles, busy clears
// [R22] software clears invalidate, then re-enables
// [R23] whole register resets to zero
// [R24] busy set cycle after invalidate written
`timescale 1ns/1ps
module l2c_ctrl
  import l2c_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_ce,
  input  wire logic                   i_spr_we,
  input  wire logic [31:0]            i_spr_wdata,
  input  wire logic                   i_ram_idle,
  input  wire logic                   i_queue_ack_in,
  output logic [31:0]                 o_spr_rdata,
  output l2c_cfg_t                    o_cfg,
  output l2c_clkcfg_t                 o_clkcfg,
  output logic                        o_ram_sleep_out,
  output logic                        o_ram_clock_out_a,
  output logic                        o_ram_clock_out_b,
  output logic                        o_dll_locked,
  output logic                        o_tag_clr,
  output logic [TAG_INDEX_W-1:0]      o_tag_idx
);

  typedef struct packed {
    logic [31:0]             ctrl;       // bit 31 unused here, busy merged on read
    logic [31:0]             rdata;
    logic                    inval_q;
    logic                    busy;
    l2c_cfg_t                cfg;
    l2c_clkcfg_t             ccfg;
    logic                    sleep;
    logic [3:0]              phase;      // half-period counter of core edges
    logic                    clk_a;
    logic                    clk_b;
    logic [DLL_CNT_W-1:0]    lock_cnt;
    logic                    locked;
    logic                    tclr;
    logic [TAG_INDEX_W-1:0]  tidx;
  } l2c_state_t;

  l2c_state_t r;
  l2c_state_t next_r;

  logic                      walk_busy;
  logic                      walk_clr;
  logic [TAG_INDEX_W-1:0]    walk_idx;
  logic                      inval_start;
  logic [2:0]                ratio;

  assign ratio       = r.ctrl[POS_CLK +: 3];
  // rising edge of the invalidate bit kicks the walker
  assign inval_start = r.ctrl[BIT_INVAL] && !r.inval_q;   // [R06]

  ////////////////////////////////////////////////////////////////////////
  l2c_inval_walk u_walk (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_ce      (i_ce),
    .i_start   (inval_start),
    .o_busy    (walk_busy),
    .o_tag_clr (walk_clr),
    .o_tag_idx (walk_idx)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    if (i_spr_we) begin
      next_r.ctrl = i_spr_wdata & WRITE_MASK;   // reserved bits stay zero
    end
    next_r.inval_q = r.ctrl[BIT_INVAL];
    // busy rises on the same edge the walker starts, drops after last tag
    next_r.busy = inval_start || walk_busy;      // [R24] [R21]
    next_r.rdata = {next_r.busy, next_r.ctrl[30:0]};   // [R15]
    next_r.tclr = walk_clr;                      // [R19]
    next_r.tidx = walk_idx;

    // decoded datapath configuration
    next_r.cfg.cache_on        = r.ctrl[BIT_ENABLE];                   // [R01]
    next_r.cfg.parity_on       = r.ctrl[BIT_PARITY];                   // [R01]
    next_r.cfg.size_sel        = r.ctrl[POS_SIZE +: 2];                // [R02]
    next_r.cfg.size_bad        = (r.ctrl[POS_SIZE +: 2] == 2'h0);
    next_r.cfg.ram_type        = r.ctrl[POS_RAM +: 2];                 // [R04]
    next_r.cfg.ram_bad         = (r.ctrl[POS_RAM +: 2] == 2'h1);
    // set means instructions may be cached, as the field table reads
    next_r.cfg.icache_allow    = r.ctrl[BIT_DATA_ONLY];                // [R05]
    next_r.cfg.write_through   = r.ctrl[BIT_WT];                       // [R08]
    next_r.cfg.l1_push_to_l2   = r.ctrl[BIT_TS];                       // [R09]
    next_r.cfg.drop_miss_store = r.ctrl[BIT_TS];                       // [R10]
    next_r.cfg.hold_long       = (r.ctrl[POS_HOLD +: 2] == 2'h1);      // [R11]
    next_r.cfg.hold_bad        = r.ctrl[POS_HOLD + 1];

    next_r.ccfg.clk_run      = (ratio != CLK_OFF);                     // [R03]
    next_r.ccfg.dll_on       = (ratio != CLK_OFF) && !r.ctrl[BIT_BYPASS]; // [R18] [R14]
    next_r.ccfg.dll_slow     = r.ctrl[BIT_DLL_SLOW];                   // [R12]
    next_r.ccfg.dll_bypass   = r.ctrl[BIT_BYPASS];                     // [R14]
    next_r.ccfg.diff_pair    = r.ctrl[BIT_DIFF];                       // [R13]
    next_r.ccfg.half_periods = ratio_half_periods(ratio);              // [R03]
    next_r.ccfg.ratio_bad    = (ratio == 3'h3) || (ratio == 3'h7);

    // sleep only when automatic control is on and the ram is quiet
    next_r.sleep = r.ctrl[BIT_SLEEP] && i_ram_idle && !r.busy
                   && !(i_queue_ack_in && !r.ctrl[BIT_ENABLE]);       // [R07]

    // ram clock: phase gains four per core edge and half_periods marks half
    // a ram period; half ratios are approximated on core edges, the dll
    // trims phase in the pad
    if (r.ccfg.half_periods == 3'h0) begin
      next_r.phase = 4'h0;
      next_r.clk_a = 1'b0;                                             // [R03]
    end else if (r.phase + 4'h4 >= {1'b0, r.ccfg.half_periods}) begin
      next_r.phase = r.phase + 4'h4 - {1'b0, r.ccfg.half_periods};
      // divide by one cannot toggle twice per core edge: cap the phase
      if (next_r.phase >= {1'b0, r.ccfg.half_periods}) begin
        next_r.phase = 4'h0;
      end
      next_r.clk_a = !r.clk_a;                                         // [R03]
    end else begin
      next_r.phase = r.phase + 4'h4;
    end
    // differential: b is the complement; else an independent copy
    next_r.clk_b = r.ccfg.diff_pair ? !next_r.clk_a : next_r.clk_a;   // [R13]

    // lock indicator counts ram clock rising edges after dll start
    if (!r.ccfg.dll_on) begin
      next_r.lock_cnt = '0;
      next_r.locked   = r.ccfg.dll_bypass && r.ccfg.clk_run;
    end else if (!r.locked && next_r.clk_a && !r.clk_a) begin
      next_r.lock_cnt = r.lock_cnt + 1'b1;
      next_r.locked   = (r.lock_cnt == DLL_CNT_W'(DLL_LOCK_CLKS - 1));  // [R17]
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;                     // cache and dll off, register zero [R16] [R23]
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_spr_rdata       = r.rdata;
  assign o_cfg             = r.cfg;
  assign o_clkcfg          = r.ccfg;
  assign o_ram_sleep_out   = r.sleep;
  assign o_ram_clock_out_a = r.clk_a;
  assign o_ram_clock_out_b = r.clk_b;
  assign o_dll_locked      = r.locked;
  assign o_tag_clr         = r.tclr;
  assign o_tag_idx         = r.tidx;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_inval_write;
    i_ce && i_spr_we && i_spr_wdata[BIT_INVAL] && !r.ctrl[BIT_INVAL];
  endsequence

  sequence s_busy_seen;
    i_ce ##1 i_ce && o_spr_rdata[BIT_BUSY];
  endsequence

  sequence s_walk_done;
    i_ce && walk_busy ##1 i_ce && !walk_busy && !inval_start;
  endsequence

  a_busy_rises: assert property (s_inval_write |=> s_busy_seen) // [R24]
    else $error("busy bit did not rise after invalidate write");
  a_busy_reads_walk: assert property ( // [R15]
    i_ce && walk_busy |=> o_spr_rdata[BIT_BUSY])
    else $error("busy bit low while walker runs");
  a_busy_ends: assert property ( // [R21]
    s_walk_done |=> !o_spr_rdata[BIT_BUSY])
    else $error("busy bit stays set after walk ended");
  a_walk_starts: assert property ( // [R06]
    i_ce && inval_start && !walk_busy |=> walk_busy)
    else $error("invalidate edge did not start walker");
  a_no_restart: assert property ( // [R06]
    i_ce && !inval_start && !walk_busy |=> !walk_busy)
    else $error("walker started without invalidate edge");
  a_tag_mirror: assert property ( // [R19]
    i_ce |=> o_tag_clr == $past(walk_clr) && o_tag_idx == $past(walk_idx))
    else $error("tag clear outputs do not follow walker");

  // decoded fields follow the stored word one enabled cycle later
  a_write_lands: assert property ( // [R01]
    i_ce && i_spr_we |=> o_spr_rdata[18:0] == $past(i_spr_wdata[18:0]))
    else $error("written control bits not read back");
  a_enable_read: assert property ( // [R01]
    i_ce ##1 i_ce |-> o_cfg.cache_on == $past(r.ctrl[BIT_ENABLE]))
    else $error("enable does not follow register");
  a_parity_read: assert property ( // [R01]
    i_ce |=> o_cfg.parity_on == $past(r.ctrl[BIT_PARITY]))
    else $error("parity enable does not follow register");
  a_size_decode: assert property ( // [R02]
    i_ce |=> o_cfg.size_sel == $past(r.ctrl[POS_SIZE +: 2]))
    else $error("size field does not follow register");
  a_size_reserved: assert property ( // [R02]
    i_ce |=> o_cfg.size_bad == ($past(r.ctrl[POS_SIZE +: 2]) == 2'h0))
    else $error("reserved size code not flagged");
  a_ram_decode: assert property ( // [R04]
    i_ce |=> o_cfg.ram_type == $past(r.ctrl[POS_RAM +: 2]))
    else $error("ram type does not follow register");
  a_ram_reserved: assert property ( // [R04]
    i_ce |=> o_cfg.ram_bad == ($past(r.ctrl[POS_RAM +: 2]) == 2'h1))
    else $error("reserved ram type not flagged");
  a_icache_allow: assert property ( // [R05]
    i_ce |=> o_cfg.icache_allow == $past(r.ctrl[BIT_DATA_ONLY]))
    else $error("instruction caching does not follow bit");
  a_write_through: assert property ( // [R08]
    i_ce |=> o_cfg.write_through == $past(r.ctrl[BIT_WT]))
    else $error("write-through does not follow bit");
  a_l1_push: assert property ( // [R09]
    i_ce |=> o_cfg.l1_push_to_l2 == $past(r.ctrl[BIT_TS]))
    else $error("l1 push steering does not follow bit");
  a_ts_drops: assert property ( // [R10]
    i_ce ##1 i_ce |-> o_cfg.drop_miss_store == $past(r.ctrl[BIT_TS]))
    else $error("test support not steering store drop");
  a_hold_decode: assert property ( // [R11]
    i_ce |=> o_cfg.hold_long == ($past(r.ctrl[POS_HOLD +: 2]) == 2'h1))
    else $error("output hold code decoded wrongly");

  // clock ratio, dll and clock pins
  a_clock_off: assert property ( // [R03]
    i_ce && ratio == CLK_OFF |=> !o_clkcfg.clk_run && !o_clkcfg.dll_on)
    else $error("zero ratio left clock or dll running");
  a_ratio_div1: assert property ( // [R03]
    i_ce && ratio == CLK_DIV1 |=> o_clkcfg.half_periods == 3'h2)
    else $error("divide by one decoded wrongly");
  a_ratio_div1p5: assert property ( // [R03]
    i_ce && ratio == CLK_DIV1P5 |=> o_clkcfg.half_periods == 3'h3)
    else $error("divide by one and a half decoded wrongly");
  a_ratio_div2: assert property ( // [R03]
    i_ce && ratio == CLK_DIV2 |=> o_clkcfg.half_periods == 3'h4)
    else $error("divide by two decoded wrongly");
  a_ratio_div2p5: assert property ( // [R03]
    i_ce && ratio == CLK_DIV2P5 |=> o_clkcfg.half_periods == 3'h5)
    else $error("divide by two and a half decoded wrongly");
  a_ratio_div3: assert property ( // [R03]
    i_ce && ratio == CLK_DIV3 |=> o_clkcfg.half_periods == 3'h6)
    else $error("divide by three decoded wrongly");
  a_ratio_reserved: assert property ( // [R03]
    i_ce && (ratio == 3'h3 || ratio == 3'h7)
    |=> o_clkcfg.ratio_bad && o_clkcfg.half_periods == 3'h0)
    else $error("reserved ratio code not flagged");
  a_dll_auto_on: assert property (i_ce && ratio != CLK_OFF && !r.ctrl[BIT_BYPASS] // [R18]
                                  |=> o_clkcfg.dll_on)
    else $error("nonzero ratio did not enable dll");
  a_dll_slow: assert property ( // [R12]
    i_ce |=> o_clkcfg.dll_slow == $past(r.ctrl[BIT_DLL_SLOW]))
    else $error("dll slow mode does not follow bit");
  a_dll_bypass: assert property ( // [R14]
    i_ce |=> o_clkcfg.dll_bypass == $past(r.ctrl[BIT_BYPASS]))
    else $error("dll bypass does not follow bit");
  a_lock_needs_dll: assert property ( // [R17]
    i_ce && !r.ccfg.dll_on && !r.ccfg.dll_bypass |=> !o_dll_locked)
    else $error("lock shown with dll off");
  a_lock_not_early: assert property ( // [R17]
    i_ce && r.ccfg.dll_on && !r.locked && r.lock_cnt < DLL_CNT_W'(DLL_LOCK_CLKS - 1)
    |=> !o_dll_locked)
    else $error("lock shown before 640 ram clocks");
  a_clk_off_zero: assert property ( // [R03]
    i_ce && r.ccfg.half_periods == 3'h0 |=> !o_ram_clock_out_a)
    else $error("ram clock runs while disabled");
  a_diff_pair: assert property ( // [R13]
    i_ce && r.ccfg.diff_pair |=> o_ram_clock_out_b != o_ram_clock_out_a)
    else $error("differential outputs not complementary");
  a_diff_off: assert property ( // [R13]
    i_ce && !r.ccfg.diff_pair |=> o_ram_clock_out_b == o_ram_clock_out_a)
    else $error("independent clock outputs differ");

  a_reserved_zero: assert property (o_spr_rdata[30:19] == 12'h000) // [R23]
    else $error("reserved bits read nonzero");
  // sleep only moves on enabled edges, so judge it against those
  a_sleep_needs_bit: assert property ( // [R07]
    $past(i_ce) && o_ram_sleep_out |-> $past(r.ctrl[BIT_SLEEP]))
    else $error("sleep driven without automatic control");

endmodule

//--- sim/l2c_tb.sv
/*
 * self-checking bench for the cache control register block: reset values,
 * field decode, ratio codes, dll lock, clock outputs, sleep and invalidation.
 * assumes the register port of l2c_ctrl only, inputs driven at falling edges.
 */
`timescale 1ns/1ps
module testbench;
  import l2c_pkg::*;
  logic                   i_clk = 1'b0;
  logic                   i_arst_n, i_ce, i_spr_we, i_ram_idle, i_queue_ack_in;
  logic [31:0]            i_spr_wdata, o_spr_rdata;
  l2c_cfg_t               o_cfg;
  l2c_clkcfg_t            o_clkcfg;
  logic                   o_ram_sleep_out, o_ram_clock_out_a, o_ram_clock_out_b;
  logic                   o_dll_locked, o_tag_clr;
  logic [TAG_INDEX_W-1:0] o_tag_idx, last;
  int                     err_total, tests_run, cyc, n, cnt, s;
  logic [2:0]             hp [8] = '{3'h0, 3'h2, 3'h3, 3'h0, 3'h4, 3'h5, 3'h6, 3'h0};

  l2c_ctrl DUT (.i_clk, .i_arst_n, .i_ce, .i_spr_we, .i_spr_wdata, .i_ram_idle,
    .i_queue_ack_in, .o_spr_rdata, .o_cfg, .o_clkcfg, .o_ram_sleep_out,
    .o_ram_clock_out_a, .o_ram_clock_out_b, .o_dll_locked, .o_tag_clr, .o_tag_idx);

  always #4 i_clk = ~i_clk;

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // returns with read word and decoded outputs both settled
  task automatic wr(logic [31:0] d);
    @(negedge i_clk);
    i_spr_we = 1'b1;
    i_spr_wdata = d;
    @(negedge i_clk);
    i_spr_we = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // walk plus dll wait stay well under this
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 50000) begin
      err_total++;
      print_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_arst_n = 1'b0; i_ce = 1'b1; i_spr_we = 1'b0; i_spr_wdata = 32'h0;
    i_ram_idle = 1'b1; i_queue_ack_in = 1'b0;
    repeat (3) @(negedge i_clk);
    i_arst_n = 1'b1;
    check("rdata", o_spr_rdata, CTRL_RESET);
    check("cfg", o_cfg, 32'h0);
    check("clkcfg", o_clkcfg, 32'h0);
    check("locked", o_dll_locked, 32'h0);
    $display("test reset done");

    // every writable bit but invalidate, reserved and busy bits written too
    wr(32'hffff_fbff);
    check("rdata", o_spr_rdata, 32'h0007_fbff);
    check("cache_on", o_cfg.cache_on, 32'h1);
    check("parity_on", o_cfg.parity_on, 32'h1);
    check("icache", o_cfg.icache_allow, 32'h1);
    check("wt", o_cfg.write_through, 32'h1);
    check("push", o_cfg.l1_push_to_l2, 32'h1);
    check("drop", o_cfg.drop_miss_store, 32'h1);
    check("slow", o_clkcfg.dll_slow, 32'h1);
    check("diff", o_clkcfg.diff_pair, 32'h1);
    check("bypass", o_clkcfg.dll_bypass, 32'h1);
    wr(32'h0);
    check("cfg", o_cfg, 32'h0000_0200); // only the reserved size flag
    check("clkcfg", o_clkcfg, 32'h0);
    for (s = 0; s < 4; s++) begin
      wr((s << POS_SIZE) | (s << POS_RAM) | (s << POS_HOLD));
      check("size", o_cfg.size_sel, s);
      check("size_bad", o_cfg.size_bad, s == 0);
      check("ram", o_cfg.ram_type, s);
      check("ram_bad", o_cfg.ram_bad, s == 1);
      check("hold_long", o_cfg.hold_long, s == 1);
      check("hold_bad", o_cfg.hold_bad, s >= 2);
    end
    for (s = 0; s < 8; s++) begin
      wr(s << POS_CLK);
      check("half", o_clkcfg.half_periods, hp[s]);
      check("ratio_bad", o_clkcfg.ratio_bad, s == 3 || s == 7);
      check("dll_on", o_clkcfg.dll_on, s != 0);
      if (hp[s] != 3'h0 || s == 0)
        check("clk_run", o_clkcfg.clk_run, s != 0);
    end
    $display("test field decode done");

    // divide by 3: three core cycles per ram clock, lock after 1920 cycles
    wr(CLK_DIV3 << POS_CLK);
    cnt = 0;
    for (n = 0; n < 30; n++) begin
      last[0] = o_ram_clock_out_a;
      @(negedge i_clk);
      if (!last[0] && o_ram_clock_out_a) cnt++;
      check("clk_b", o_ram_clock_out_b, o_ram_clock_out_a);
    end
    check("rises", cnt, 32'd10);
    repeat (1650) @(negedge i_clk);
    check("early_lock", o_dll_locked, 32'h0);
    for (n = 0; n < 600 && !o_dll_locked; n++) @(negedge i_clk);
    check("locked", o_dll_locked, 32'h1);
    wr((CLK_DIV3 << POS_CLK) | (32'h1 << BIT_DIFF));
    repeat (5) begin
      @(negedge i_clk);
      check("clk_b", o_ram_clock_out_b, !o_ram_clock_out_a);
    end
    $display("test clocking done");

    wr(32'h1 << BIT_SLEEP);
    repeat (4) @(negedge i_clk);
    check("sleep", o_ram_sleep_out, 32'h1);
    i_queue_ack_in = 1'b1;
    repeat (4) @(negedge i_clk);
    check("sleep_queue_ack_in", o_ram_sleep_out, 32'h0);
    i_queue_ack_in = 1'b0;
    wr(32'h0);
    repeat (4) @(negedge i_clk);
    check("sleep_off", o_ram_sleep_out, 32'h0);
    i_ce = 1'b0;
    wr(32'h1);
    check("frozen", o_spr_rdata, 32'h0);
    i_ce = 1'b1;
    $display("test sleep and enable done");

    wr(32'h1 << BIT_INVAL); // cache already disabled
    check("busy_set", o_spr_rdata[BIT_BUSY], 32'h1);
    cnt = 0;
    last = '0;
    for (n = 0; n < 33000 && o_spr_rdata[BIT_BUSY]; n++) begin
      @(negedge i_clk);
      if (o_tag_clr === 1'b1) begin
        last = o_tag_idx;
        cnt++;
      end
    end
    check("last_idx", last, TAG_LAST);
    check("clears_ok", cnt >= INVAL_CYCLES, 32'h1);
    check("walk_len", n >= INVAL_CYCLES - 2 && n <= INVAL_CYCLES + 8, 32'h1);
    check("rdata", o_spr_rdata, 32'h1 << BIT_INVAL);
    wr(32'h1 << BIT_INVAL);
    check("no_restart", o_spr_rdata[BIT_BUSY], 32'h0);
    wr(32'h1);
    check("reenable", o_spr_rdata, 32'h1);
    check("cache_on", o_cfg.cache_on, 32'h1);
    $display("test invalidation done");

    i_arst_n = 1'b0;
    @(negedge i_clk);
    i_arst_n = 1'b1;
    check("rdata", o_spr_rdata, CTRL_RESET);
    check("cfg", o_cfg, 32'h0);
    $display("test second reset done");
    print_verdict();
  end
endmodule
